// file: toim_pkg.sv
// Package: constants and types for the torque-off input monitor
package toim_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 250_000_000;
  localparam int unsigned DISC_TIME_MS = 100;
  localparam int unsigned PULSE_TOL_US = 3500;
  localparam int unsigned EVAL_PERIOD_MS = 10;
  localparam int unsigned PWM_CUT_US = 125;
  localparam int unsigned BRAKE_TIME_MS = 10;
  localparam int unsigned PWR_MASK_MS = 100;
  localparam int unsigned CYC_PER_US = CLK_FREQ_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS = CLK_FREQ_HZ / 1_000;
  localparam int unsigned DISC_CYC = DISC_TIME_MS * CYC_PER_MS;
  localparam int unsigned PULSE_TOL_CYC = PULSE_TOL_US * CYC_PER_US;
  localparam int unsigned EVAL_CYC = EVAL_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned PWM_CUT_CYC = PWM_CUT_US * CYC_PER_US;
  localparam int unsigned BRAKE_CYC = BRAKE_TIME_MS * CYC_PER_MS;
  localparam int unsigned PWR_MASK_CYC = PWR_MASK_MS * CYC_PER_MS;
  localparam int unsigned CNT_W = 26;
  // ----------------------------------------
  // Diagnostic states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_DISC = 4'h2,
    ST_OFF = 4'h4,
    ST_FAULT = 4'h8
  } toim_state_type;
endpackage : toim_pkg

// file: toim_chan_filter.sv
// Per-channel synchroniser and test-pulse filter
`timescale 1ns/100ps
module toim_chan_filter #(
  parameter int unsigned PULSE_CYC = toim_pkg::PULSE_TOL_CYC,
  parameter int unsigned CW = toim_pkg::CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw request level and filtered result
  input wire logic req_in,
  output logic req_flt
);
  import toim_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic [CW-1:0] low_cnt_q;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= req_in;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------
  // Low level accepted only after pulse tolerance
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_cnt_q <= '0;
      req_flt <= 1'b1;
    end else if (sync2_q) begin
      low_cnt_q <= '0;
      req_flt <= 1'b1;
    end else if (low_cnt_q < CW'(PULSE_CYC)) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end else begin
      req_flt <= 1'b0;
    end
  end
endmodule : toim_chan_filter

// file: toim_monitor.sv
// Torque-off input monitor top level
`timescale 1ns/100ps
module toim_monitor
  import toim_pkg::*;
#(
  parameter int unsigned DISC_CYCLES = toim_pkg::DISC_CYC,
  parameter int unsigned PULSE_CYCLES = toim_pkg::PULSE_TOL_CYC,
  parameter int unsigned EVAL_CYCLES = toim_pkg::EVAL_CYC,
  parameter int unsigned PWM_CYCLES = toim_pkg::PWM_CUT_CYC,
  parameter int unsigned BRAKE_CYCLES = toim_pkg::BRAKE_CYC,
  parameter int unsigned MASK_CYCLES = toim_pkg::PWR_MASK_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Request inputs, high while running
  input wire logic STOP_REQUEST_CHAN_A,
  input wire logic STOP_REQUEST_CHAN_B,
  // Driver-supply channel states, high while supplied
  input wire logic DRV_SUPPLY_OK_A,
  input wire logic DRV_SUPPLY_OK_B,
  // Configuration and acknowledgement
  input wire logic BRAKE_CONFIGURED,
  input wire logic ERROR_ACK,
  // Feedback contact, lamp and power-up mask
  output logic FEEDBACK_CONTACT_CLOSED,
  output logic LAMP_GREEN,
  output logic LAMP_YELLOW,
  output logic POWERUP_MASK,
  // Drive side
  output logic PWM_ENABLE,
  output logic DRIVE_ENABLE,
  output logic BRAKE_RELEASE,
  // Diagnostics
  output logic DISC_ERROR,
  output logic SUPPLY_DISC_ERROR,
  output logic [3:0] DIAG_STATE
);
  import toim_pkg::*;

  logic flt_a;
  logic flt_b;
  logic [CNT_W-1:0] disc_cnt_q;
  logic [CNT_W-1:0] eval_cnt_q;
  logic [CNT_W-1:0] sdisc_cnt_q;
  logic [CNT_W-1:0] pwm_cnt_q;
  logic [CNT_W-1:0] brk_cnt_q;
  logic [CNT_W-1:0] mask_cnt_q;
  logic sto_q;
  logic disc_err_q;
  logic sdisc_err_q;
  logic sup_fail;
  logic eval_tick;
  logic sup_a_q;
  logic sup_b_q;
  toim_state_type state_q;
  toim_state_type state_d;

  // ----------------------------------------
  // Channel conditioning
  // ----------------------------------------
  toim_chan_filter #(.PULSE_CYC(PULSE_CYCLES), .CW(CNT_W)) u_flt_a (
    .clk(CLK),
    .rst_n(RST_N),
    .req_in(STOP_REQUEST_CHAN_A),
    .req_flt(flt_a)
  );
  toim_chan_filter #(.PULSE_CYC(PULSE_CYCLES), .CW(CNT_W)) u_flt_b (
    .clk(CLK),
    .rst_n(RST_N),
    .req_in(STOP_REQUEST_CHAN_B),
    .req_flt(flt_b)
  );

  // ----------------------------------------
  // Request discrepancy timing
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      disc_cnt_q <= '0;
    end else if (flt_a == flt_b) begin
      disc_cnt_q <= '0;
    end else if (disc_cnt_q < CNT_W'(DISC_CYCLES)) begin
      disc_cnt_q <= disc_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Torque-off state and request error
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sto_q <= 1'b0;
    end else begin
      sto_q <= !flt_a && !flt_b;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      disc_err_q <= 1'b0;
    end else if (disc_cnt_q >= CNT_W'(DISC_CYCLES)) begin
      disc_err_q <= 1'b1;
    end else if (ERROR_ACK) begin
      disc_err_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Supply evaluation every 10 ms
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      eval_cnt_q <= '0;
    end else if (eval_tick) begin
      eval_cnt_q <= '0;
    end else begin
      eval_cnt_q <= eval_cnt_q + 1'b1;
    end
  end
  assign eval_tick = (eval_cnt_q == CNT_W'(EVAL_CYCLES - 1));

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sup_a_q <= 1'b1;
      sup_b_q <= 1'b1;
      sdisc_cnt_q <= '0;
    end else if (eval_tick) begin
      sup_a_q <= DRV_SUPPLY_OK_A;
      sup_b_q <= DRV_SUPPLY_OK_B;
      if (DRV_SUPPLY_OK_A == DRV_SUPPLY_OK_B) begin
        sdisc_cnt_q <= '0;
      end else if (sdisc_cnt_q <= CNT_W'(DISC_CYCLES)) begin
        sdisc_cnt_q <= sdisc_cnt_q + CNT_W'(EVAL_CYCLES);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sdisc_err_q <= 1'b0;
    end else if (sdisc_cnt_q > CNT_W'(DISC_CYCLES)) begin
      sdisc_err_q <= 1'b1;
    end else if (ERROR_ACK) begin
      sdisc_err_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Diagnostic state machine on the 10 ms tick
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (sdisc_err_q) state_d = ST_FAULT;
        else if (!sup_a_q && !sup_b_q) state_d = ST_OFF;
        else if (sup_a_q != sup_b_q) state_d = ST_DISC;
      end
      ST_DISC: begin
        if (sdisc_err_q) state_d = ST_FAULT;
        else if (!sup_a_q && !sup_b_q) state_d = ST_OFF;
        else if (sup_a_q && sup_b_q) state_d = ST_RUN;
      end
      ST_OFF: begin
        if (sup_a_q && sup_b_q) state_d = ST_RUN;
        else if (sup_a_q != sup_b_q) state_d = ST_DISC;
      end
      ST_FAULT: begin
        if (!sdisc_err_q) state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= ST_RUN;
    end else if (eval_tick) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // PWM and brake timers after supply failure; no output uses them, all three are cut on the next clock
  // ----------------------------------------
  assign sup_fail = !DRV_SUPPLY_OK_A || !DRV_SUPPLY_OK_B;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pwm_cnt_q <= '0;
      brk_cnt_q <= '0;
    end else if (!sup_fail) begin
      pwm_cnt_q <= '0;
      brk_cnt_q <= '0;
    end else begin
      if (pwm_cnt_q < CNT_W'(PWM_CYCLES)) pwm_cnt_q <= pwm_cnt_q + 1'b1;
      if (brk_cnt_q < CNT_W'(BRAKE_CYCLES)) brk_cnt_q <= brk_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PWM_ENABLE <= 1'b0;
      DRIVE_ENABLE <= 1'b0;
      BRAKE_RELEASE <= 1'b0;
    end else begin
      PWM_ENABLE <= !sup_fail && !sto_q;
      DRIVE_ENABLE <= !sto_q && !sup_fail;
      BRAKE_RELEASE <= BRAKE_CONFIGURED && !sto_q && !sup_fail;
    end
  end

  // ----------------------------------------
  // Feedback contact, lamp and power-up mask
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mask_cnt_q <= '0;
    end else if (mask_cnt_q < CNT_W'(MASK_CYCLES)) begin
      mask_cnt_q <= mask_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      FEEDBACK_CONTACT_CLOSED <= 1'b0;
      LAMP_GREEN <= 1'b0;
      LAMP_YELLOW <= 1'b0;
      POWERUP_MASK <= 1'b1;
      DISC_ERROR <= 1'b0;
      SUPPLY_DISC_ERROR <= 1'b0;
      DIAG_STATE <= ST_RUN;
    end else begin
      FEEDBACK_CONTACT_CLOSED <= sto_q;
      LAMP_GREEN <= !sto_q;
      LAMP_YELLOW <= sto_q;
      POWERUP_MASK <= (mask_cnt_q < CNT_W'(MASK_CYCLES));
      DISC_ERROR <= disc_err_q;
      SUPPLY_DISC_ERROR <= sdisc_err_q;
      DIAG_STATE <= state_q;
    end
  end
endmodule : toim_monitor

// file: toim_monitor_assertions.sv
// Checker for the torque-off input monitor ports
`timescale 1ns/100ps
module toim_monitor_chk #(
  parameter int unsigned DISC_CYCLES = 200,
  parameter int unsigned PULSE_CYCLES = 20,
  parameter int unsigned EVAL_CYCLES = 16,
  parameter int unsigned MASK_CYCLES = 50
) (
  // Clock, reset and inputs
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic STOP_REQUEST_CHAN_A,
  input wire logic STOP_REQUEST_CHAN_B,
  input wire logic DRV_SUPPLY_OK_A,
  input wire logic DRV_SUPPLY_OK_B,
  input wire logic BRAKE_CONFIGURED,
  input wire logic ERROR_ACK,
  // Outputs watched
  input wire logic FEEDBACK_CONTACT_CLOSED,
  input wire logic LAMP_GREEN,
  input wire logic LAMP_YELLOW,
  input wire logic POWERUP_MASK,
  input wire logic PWM_ENABLE,
  input wire logic DRIVE_ENABLE,
  input wire logic BRAKE_RELEASE,
  input wire logic DISC_ERROR,
  input wire logic SUPPLY_DISC_ERROR
);
  // ----------------------------------------
  // Run-length counters: A low, B low, A!=B, A==B, supply unequal, up time
  // ----------------------------------------
  logic [5:0] cond;
  logic [15:0] cnt_q [6];
  assign cond = {1'b1, DRV_SUPPLY_OK_A != DRV_SUPPLY_OK_B,
    STOP_REQUEST_CHAN_A == STOP_REQUEST_CHAN_B, STOP_REQUEST_CHAN_A != STOP_REQUEST_CHAN_B,
    !STOP_REQUEST_CHAN_B, !STOP_REQUEST_CHAN_A};
  always_ff @(posedge CLK) begin
    for (int i = 0; i < 6; i++) begin
      if (!RST_N || !cond[i]) cnt_q[i] <= '0;
      else if (cnt_q[i] != 16'hFFFF) cnt_q[i] <= cnt_q[i] + 16'h0001;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_ack_quiet;
    ERROR_ACK && cnt_q[3] >= PULSE_CYCLES + 8;
  endsequence
  a_close_needs_both: assert property ($rose(FEEDBACK_CONTACT_CLOSED) |->
    cnt_q[0] >= PULSE_CYCLES && cnt_q[1] >= PULSE_CYCLES) else $error("contact closed early");
  a_close_on_both: assert property (
    cnt_q[0] >= PULSE_CYCLES + 8 && cnt_q[1] >= PULSE_CYCLES + 8
    |-> FEEDBACK_CONTACT_CLOSED) else $error("contact not closed");
  a_lamp_follows: assert property ($past(RST_N) && $past(RST_N, 2) |->
    LAMP_YELLOW == FEEDBACK_CONTACT_CLOSED && LAMP_GREEN != FEEDBACK_CONTACT_CLOSED)
    else $error("lamp differs from contact");
  a_supply_cut: assert property (!(DRV_SUPPLY_OK_A && DRV_SUPPLY_OK_B) |=>
    !PWM_ENABLE && !DRIVE_ENABLE && !BRAKE_RELEASE) else $error("drive not cut");
  a_brake_unconf: assert property (!BRAKE_CONFIGURED |=> !BRAKE_RELEASE)
    else $error("brake released without brake");
  a_off_drive: assert property (FEEDBACK_CONTACT_CLOSED |->
    !DRIVE_ENABLE && !PWM_ENABLE && !BRAKE_RELEASE) else $error("drive on in torque-off");
  a_disc_raise: assert property (
    cnt_q[2] == DISC_CYCLES + PULSE_CYCLES + 8 |-> DISC_ERROR)
    else $error("no discrepancy error");
  a_ack_clears: assert property (s_ack_quiet |-> ##2 !DISC_ERROR)
    else $error("error not cleared");
  a_supply_disc: assert property (cnt_q[4] == DISC_CYCLES + 3 * EVAL_CYCLES
    |-> SUPPLY_DISC_ERROR) else $error("no supply error");
  a_mask_ends: assert property (cnt_q[5] == MASK_CYCLES + 2 |-> !POWERUP_MASK)
    else $error("mask too long");
  a_mask_holds: assert property (cnt_q[5] < MASK_CYCLES |-> POWERUP_MASK)
    else $error("mask too short");
endmodule : toim_monitor_chk
bind toim_monitor toim_monitor_chk #(.DISC_CYCLES(DISC_CYCLES), .PULSE_CYCLES(PULSE_CYCLES),
  .EVAL_CYCLES(EVAL_CYCLES), .MASK_CYCLES(MASK_CYCLES)) u_chk (.CLK(CLK), .RST_N(RST_N),
  .STOP_REQUEST_CHAN_A(STOP_REQUEST_CHAN_A), .STOP_REQUEST_CHAN_B(STOP_REQUEST_CHAN_B),
  .DRV_SUPPLY_OK_A(DRV_SUPPLY_OK_A), .DRV_SUPPLY_OK_B(DRV_SUPPLY_OK_B),
  .BRAKE_CONFIGURED(BRAKE_CONFIGURED), .ERROR_ACK(ERROR_ACK),
  .FEEDBACK_CONTACT_CLOSED(FEEDBACK_CONTACT_CLOSED), .LAMP_GREEN(LAMP_GREEN),
  .LAMP_YELLOW(LAMP_YELLOW), .POWERUP_MASK(POWERUP_MASK), .PWM_ENABLE(PWM_ENABLE),
  .DRIVE_ENABLE(DRIVE_ENABLE), .BRAKE_RELEASE(BRAKE_RELEASE), .DISC_ERROR(DISC_ERROR),
  .SUPPLY_DISC_ERROR(SUPPLY_DISC_ERROR));

// file: toim_safety_dev.sv
// Model of the safety switching device driving both request inputs
`timescale 1ns/100ps
module toim_safety_dev (
  // Clock and commands
  input wire logic clk,
  input wire logic off_cmd,
  input wire logic pulse,
  input wire logic stuck_b,
  input wire logic [9:0] skew,
  // Request lines
  output logic req_a,
  output logic req_b
);
  logic [9:0] dly_q = 10'h000;
  always @(negedge clk) begin
    dly_q <= off_cmd ? dly_q + {9'h000, dly_q != 10'h3FF} : 10'h000;
    req_a <= !(off_cmd || pulse);
    req_b <= !((off_cmd && dly_q >= skew && !stuck_b) || pulse);
  end
endmodule : toim_safety_dev

// file: tb_toim_monitor.sv
// Self-checking testbench for the torque-off input monitor
`timescale 1ns/100ps
module tb_toim_monitor;
  import toim_pkg::*;
  localparam int P = 20;
  localparam int D = 200;
  localparam int E = 16;
  localparam int M = 50;
  logic clk = 1'b0, rst_n = 1'b0, ok_a = 1'b1, ok_b = 1'b1, bcfg = 1'b1, ack = 1'b0;
  logic off_cmd = 1'b0, pulse = 1'b0, stuck_b = 1'b0;
  logic [9:0] skew = 10'h000;
  logic ra, rb, fb, lg, ly, msk, pwm, drv, brk, de, sde;
  logic [3:0] st;
  int miscompares = 0;
  int checks = 0;
  always #2 clk = ~clk;
  toim_safety_dev dev (.clk(clk), .off_cmd(off_cmd), .pulse(pulse), .stuck_b(stuck_b),
    .skew(skew), .req_a(ra), .req_b(rb));
  toim_monitor #(.DISC_CYCLES(D), .PULSE_CYCLES(P), .EVAL_CYCLES(E), .PWM_CYCLES(8),
    .BRAKE_CYCLES(16), .MASK_CYCLES(M)) uut (.CLK(clk), .RST_N(rst_n),
    .STOP_REQUEST_CHAN_A(ra), .STOP_REQUEST_CHAN_B(rb), .DRV_SUPPLY_OK_A(ok_a),
    .DRV_SUPPLY_OK_B(ok_b), .BRAKE_CONFIGURED(bcfg), .ERROR_ACK(ack),
    .FEEDBACK_CONTACT_CLOSED(fb), .LAMP_GREEN(lg), .LAMP_YELLOW(ly), .POWERUP_MASK(msk),
    .PWM_ENABLE(pwm), .DRIVE_ENABLE(drv), .BRAKE_RELEASE(brk), .DISC_ERROR(de),
    .SUPPLY_DISC_ERROR(sde), .DIAG_STATE(st));
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : check_bit
  task automatic check_st(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: state %h not %h", $time, got, exp);
    end
  endtask : check_st
  task automatic t_powerup;
    cyc(1);
    check_bit(msk, 1'b1);
    cyc(M + 5);
    check_bit(msk, 1'b0);
    check_bit(lg, 1'b1);
    check_bit(fb, 1'b0);
    check_bit(pwm & drv & brk, 1'b1);
    check_st(st, ST_RUN);
  endtask : t_powerup
  task automatic t_brake;
    bcfg <= 1'b0;
    cyc(3);
    check_bit(brk, 1'b0);
    bcfg <= 1'b1;
    cyc(3);
    check_bit(brk, 1'b1);
  endtask : t_brake
  task automatic t_pulse;
    pulse <= 1'b1;
    cyc(P - 2);
    check_bit(fb, 1'b0);
    cyc(2);
    pulse <= 1'b0;
    cyc(P + 10);
    check_bit(fb, 1'b0);
    check_bit(lg, 1'b1);
  endtask : t_pulse
  task automatic t_stop(input logic [9:0] s);
    skew <= s;
    off_cmd <= 1'b1;
    cyc(s + P + 12);
    check_bit(fb, 1'b1);
    check_bit(ly & !lg, 1'b1);
    check_bit(pwm | drv | brk, 1'b0);
    check_bit(de, 1'b0);
    off_cmd <= 1'b0;
    cyc(10);
    check_bit(fb, 1'b0);
  endtask : t_stop
  task automatic t_single;
    stuck_b <= 1'b1;
    off_cmd <= 1'b1;
    cyc(P + 30);
    check_bit(fb | de, 1'b0);
    cyc(D + 10);
    check_bit(de, 1'b1);
    check_bit(fb, 1'b0);
    off_cmd <= 1'b0;
    stuck_b <= 1'b0;
    cyc(P + 10);
    ack <= 1'b1;
    cyc(1);
    ack <= 1'b0;
    cyc(2);
    check_bit(de, 1'b0);
  endtask : t_single
  task automatic t_supply;
    ok_a <= 1'b0;
    cyc(2);
    check_bit(pwm | drv | brk, 1'b0);
    cyc(3 * E);
    check_st(st, ST_DISC);
    cyc(D + E);
    check_bit(sde, 1'b1);
    check_st(st, ST_FAULT);
    ok_a <= 1'b1;
    cyc(E);
    ack <= 1'b1;
    cyc(1);
    ack <= 1'b0;
    cyc(3 * E);
    check_bit(sde, 1'b0);
    check_st(st, ST_RUN);
    ok_a <= 1'b0;
    ok_b <= 1'b0;
    cyc(3 * E);
    check_st(st, ST_OFF);
    check_bit(sde | pwm, 1'b0);
    ok_a <= 1'b1;
    ok_b <= 1'b1;
    cyc(3 * E);
    check_st(st, ST_RUN);
    check_bit(pwm & drv & brk, 1'b1);
  endtask : t_supply
  initial begin
    cyc(8);
    rst_n <= 1'b1;
    t_powerup();
    t_brake();
    t_pulse();
    t_stop(10'h000);
    t_stop(10'h064);
    t_single();
    t_supply();
    conclude();
  end
  initial begin
    #40000;
    miscompares++;
    conclude();
  end
endmodule : tb_toim_monitor
